// ==== gfst_pkg.sv ====
// shared constants and carrier types of the self-test sequencer
package gfst_pkg;
  // clock and time base
  localparam int CLK_PERIOD_PS = 8000;
  localparam int TICK_US = 1000;
  localparam int TICK_CYCLES = (TICK_US * 1000 * 1000) / CLK_PERIOD_PS;
  localparam int TCNT_W = 17;
  localparam int TMR_W = 23;

  // timer periods and the end-of-life blink frequency in their own units
  localparam int FIRST_MS = 1016;
  localparam int PERIOD_S = 5400;
  localparam int TESTOUT_MS = 66;
  localparam int PHASE_MS = 60;
  localparam int EOL_FREQ_MHZ = 3750;

  // timer periods in ticks
  localparam int FIRST_TICKS = (FIRST_MS * 1000) / TICK_US;
  // divide first: seconds times a million overflows a 32-bit int
  localparam int PERIOD_TICKS = PERIOD_S * (1000000 / TICK_US);
  localparam int TESTOUT_TICKS = (TESTOUT_MS * 1000) / TICK_US;
  localparam int PHASE_TICKS = (PHASE_MS * 1000) / TICK_US;
  localparam int BLINK_HALF_MS = 1000000 / (2 * EOL_FREQ_MHZ);
  localparam int BLINK_TICKS = (BLINK_HALF_MS * 1000) / TICK_US;

  typedef enum logic [2:0] {
    GFST_FIRST,
    GFST_IDLE,
    GFST_POS,
    GFST_BIAS,
    GFST_INJ,
    GFST_CHECK,
    GFST_EOL
  } gfst_state_t;

  typedef struct packed {
    logic pos_half;    // phase comparator: positive half-cycle
    logic near_end;    // phase comparator: near end of positive half
    logic anode_sense; // anode comparator: current above threshold
  } gfst_sense_t;

  typedef struct packed {
    logic bias_en;      // anode-sense pre-charge source
    logic fault_inject; // simulated ground fault drive
  } gfst_drive_t;
endpackage : gfst_pkg

// ==== gfst_timer.sv ====
// one-shot down-counting timer stepped by the shared time-base tick
`timescale 1ns/1ps
module gfst_timer #(
  parameter int W = 23
) (
  input wire logic clk_i,            // system clock
  input wire logic rstn_i,           // synchronous reset, active low
  input wire logic start_i,          // load and run
  input wire logic stop_i,           // abandon a running count
  input wire logic tick_i,           // time-base tick
  input wire logic [W-1:0] load_i,   // period in ticks, at least one
  output logic done_o,               // one-cycle expiry pulse
  output logic busy_o                // counting
);
  logic [W-1:0] cnt;

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      cnt <= '0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i) begin
        cnt <= load_i;
        busy_o <= 1'b1;
      end else if (stop_i) begin
        busy_o <= 1'b0;
      end else if (busy_o && tick_i) begin
        if (cnt <= W'(1)) begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
        end else begin
          cnt <= cnt - W'(1);
        end
      end
    end
  end
endmodule : gfst_timer

// ==== gfst_seq.sv ====
// self-test sequencer of a ground-fault interrupter
`timescale 1ns/1ps
module gfst_seq
  import gfst_pkg::*;
#(
  parameter int TICK_CYC = gfst_pkg::TICK_CYCLES,
  parameter int FIRST_T = gfst_pkg::FIRST_TICKS,
  parameter int PERIOD_T = gfst_pkg::PERIOD_TICKS,
  parameter int TESTOUT_T = gfst_pkg::TESTOUT_TICKS,
  parameter int PHASE_T = gfst_pkg::PHASE_TICKS,
  parameter int BLINK_T = gfst_pkg::BLINK_TICKS
) (
  input wire logic clk_i,                    // system clock, 125 MHz
  input wire logic rstn_i,                   // power-on reset, active low
  input wire gfst_pkg::gfst_sense_t sense_i, // filtered comparator levels
  output gfst_pkg::gfst_drive_t drive_o,     // test drive to the pins
  output logic end_of_life_alarm_o,          // end-of-life alarm pin
  output logic test_active_o,                // a test cycle is running
  output logic pass_o,                       // one-cycle pulse on a pass
  output logic phase_fail_o                  // alarm came from the phase check
);
  import gfst_pkg::*;

  gfst_state_t state;
  gfst_state_t next_state;
  logic [TCNT_W-1:0] tick_cnt;
  logic tick;
  logic booted;
  logic prev_pos;
  logic prev_near;
  logic cont_ok;
  logic trig_ok;
  logic phase_seen;
  logic first_start;
  logic first_done;
  logic tout_start;
  logic tout_stop;
  logic tout_done;
  logic phase_done;
  logic blink_start;
  logic blink_done;
  logic near_rise;
  logic pos_fall;
  logic pos_rise;
  logic in_test;
  logic phase_bad;

  // the four states of a running test cycle
  function automatic logic is_test(input gfst_state_t s);
    return (s == GFST_POS) || (s == GFST_BIAS) || (s == GFST_INJ) || (s == GFST_CHECK);
  endfunction : is_test

  // one free-running time base; every timer counts its ticks
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      tick_cnt <= '0;
      tick <= 1'b0;
    end else if (tick_cnt == TCNT_W'(TICK_CYC - 1)) begin
      tick_cnt <= '0;
      tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + TCNT_W'(1);
      tick <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      booted <= 1'b0;
      prev_pos <= 1'b0;
      prev_near <= 1'b0;
    end else begin
      booted <= 1'b1;
      prev_pos <= sense_i.pos_half;
      prev_near <= sense_i.near_end;
    end
  end

  // the first sample after reset has no true previous level, so no edge is taken
  // then: a phase pin stuck high must not pass the phase check
  assign near_rise = booted && sense_i.near_end && !prev_near;
  assign pos_fall = booted && !sense_i.pos_half && prev_pos;
  assign pos_rise = booted && sense_i.pos_half && !prev_pos;
  assign in_test = is_test(state);
  // an open or shorted phase pin never toggles
  assign phase_bad = phase_done && !phase_seen && !(pos_fall || pos_rise);

  always_comb begin
    next_state = state;
    case (state)
      GFST_FIRST: if (first_done) next_state = GFST_POS;
      GFST_IDLE: if (first_done) next_state = GFST_POS;
      GFST_POS: if (near_rise) next_state = GFST_BIAS;
      GFST_BIAS: if (pos_fall) next_state = GFST_INJ;
      GFST_INJ: begin
        if (!sense_i.anode_sense) next_state = GFST_CHECK;
        else if (pos_rise) next_state = GFST_POS; // no trigger: retry
      end
      GFST_CHECK: next_state = cont_ok ? GFST_IDLE : GFST_POS;
      GFST_EOL: next_state = GFST_EOL;
      default: next_state = GFST_FIRST;
    endcase
    // time-out outranks a pass landing in the same cycle
    if (in_test && tout_done) next_state = GFST_EOL;
    if (phase_bad) next_state = GFST_EOL;
  end

  assign first_start = !booted ||
                       (state == GFST_CHECK && next_state == GFST_IDLE);
  assign tout_start = (state == GFST_FIRST || state == GFST_IDLE) &&
                      next_state == GFST_POS;
  assign tout_stop = next_state == GFST_IDLE || next_state == GFST_EOL;
  assign blink_start = next_state == GFST_EOL && (state != GFST_EOL || blink_done);

  always_ff @(posedge clk_i) begin
    if (!rstn_i) state <= GFST_FIRST;
    else state <= next_state;
  end

  // cycle latches
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      cont_ok <= 1'b0;
      trig_ok <= 1'b0;
    end else if (next_state == GFST_IDLE || next_state == GFST_EOL) begin
      cont_ok <= 1'b0;
      trig_ok <= 1'b0;
    end else begin
      if ((state == GFST_POS || state == GFST_BIAS) && sense_i.pos_half && sense_i.anode_sense)
        cont_ok <= 1'b1;
      if (state == GFST_INJ && !sense_i.anode_sense)
        trig_ok <= 1'b1;
      else if (state == GFST_CHECK)
        trig_ok <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) phase_seen <= 1'b0;
    else if (pos_fall || pos_rise) phase_seen <= 1'b1;
  end

  // drive follows the next state so it drops in the cycle after a trigger
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      drive_o <= '0;
    end else begin
      drive_o.bias_en <= next_state == GFST_BIAS || next_state == GFST_INJ;
      drive_o.fault_inject <= next_state == GFST_INJ;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      end_of_life_alarm_o <= 1'b0;
      phase_fail_o <= 1'b0;
      pass_o <= 1'b0;
      test_active_o <= 1'b0;
    end else begin
      if (next_state != GFST_EOL) end_of_life_alarm_o <= 1'b0;
      else if (state != GFST_EOL) end_of_life_alarm_o <= 1'b1;
      else if (blink_done) end_of_life_alarm_o <= !end_of_life_alarm_o;
      if (phase_bad && state != GFST_EOL) phase_fail_o <= 1'b1;
      pass_o <= state == GFST_CHECK && next_state == GFST_IDLE;
      test_active_o <= is_test(next_state);
    end
  end

  gfst_timer #(.W(TMR_W)) u_first (
    .clk_i(clk_i), .rstn_i(rstn_i), .start_i(first_start), .stop_i(1'b0),
    .tick_i(tick), .load_i(booted ? TMR_W'(PERIOD_T) : TMR_W'(FIRST_T)),
    .done_o(first_done), .busy_o()
  );
  gfst_timer #(.W(TMR_W)) u_tout (
    .clk_i(clk_i), .rstn_i(rstn_i), .start_i(tout_start), .stop_i(tout_stop),
    .tick_i(tick), .load_i(TMR_W'(TESTOUT_T)), .done_o(tout_done), .busy_o()
  );
  gfst_timer #(.W(TMR_W)) u_phase (
    .clk_i(clk_i), .rstn_i(rstn_i), .start_i(!booted), .stop_i(1'b0),
    .tick_i(tick), .load_i(TMR_W'(PHASE_T)), .done_o(phase_done), .busy_o()
  );
  gfst_timer #(.W(TMR_W)) u_blink (
    .clk_i(clk_i), .rstn_i(rstn_i), .start_i(blink_start), .stop_i(1'b0),
    .tick_i(tick), .load_i(TMR_W'(BLINK_T)), .done_o(blink_done), .busy_o()
  );

  a_reset_state: assert property (@(posedge clk_i) disable iff (!rstn_i)
    $rose(rstn_i) |-> state == GFST_FIRST && !end_of_life_alarm_o && drive_o == '0)
    else $error("state not cleared by reset");
  a_first_go: assert property (@(posedge clk_i) disable iff (!rstn_i)
    state == GFST_FIRST && first_done && !phase_bad |=> state == GFST_POS && test_active_o)
    else $error("first cycle did not start");
  a_cont_latch: assert property (@(posedge clk_i) disable iff (!rstn_i)
    state == GFST_POS && sense_i.pos_half && sense_i.anode_sense &&
    next_state == GFST_BIAS |=> cont_ok)
    else $error("continuity latch missed");
  a_near_bias: assert property (@(posedge clk_i) disable iff (!rstn_i)
    state == GFST_POS && near_rise && !tout_done && !phase_bad |=> drive_o.bias_en)
    else $error("bias not enabled near end of half-cycle");
  a_inject_start: assert property (@(posedge clk_i) disable iff (!rstn_i)
    state == GFST_BIAS && pos_fall && !tout_done && !phase_bad |=> drive_o.fault_inject)
    else $error("fault injection did not start");
  a_inj_bias: assert property (@(posedge clk_i) disable iff (!rstn_i)
    drive_o.fault_inject |-> drive_o.bias_en)
    else $error("injection without bias");
  a_trig_release: assert property (@(posedge clk_i) disable iff (!rstn_i)
    state == GFST_INJ && !sense_i.anode_sense && !tout_done && !phase_bad |=>
    trig_ok && !drive_o.fault_inject &&
    !drive_o.bias_en)
    else $error("drive not removed after trigger");
  a_pass_idle: assert property (@(posedge clk_i) disable iff (!rstn_i)
    state == GFST_CHECK && cont_ok && trig_ok && !tout_done && !phase_bad |=>
    pass_o && state == GFST_IDLE ##1 !pass_o && !cont_ok && !trig_ok)
    else $error("passing cycle not closed");
  a_tout_eol: assert property (@(posedge clk_i) disable iff (!rstn_i)
    in_test && tout_done |=> state == GFST_EOL && end_of_life_alarm_o)
    else $error("time-out did not latch alarm");
  a_phase_eol: assert property (@(posedge clk_i) disable iff (!rstn_i)
    phase_bad && state != GFST_EOL |=> state == GFST_EOL && phase_fail_o)
    else $error("phase check failure missed");
  a_blink_edge: assert property (@(posedge clk_i) disable iff (!rstn_i)
    state == GFST_EOL && blink_done |=> end_of_life_alarm_o != $past(end_of_life_alarm_o))
    else $error("alarm did not toggle");
  a_period_go: assert property (@(posedge clk_i) disable iff (!rstn_i)
    state == GFST_IDLE && first_done && !phase_bad |=> state == GFST_POS)
    else $error("periodic cycle did not start");
endmodule : gfst_seq

// ==== gfst_partner.sv ====
// far-side model: line phase comparators, anode sense network, fault controller
`timescale 1ns/1ps
module gfst_partner
  import gfst_pkg::*;
(
  input wire logic clk_i,                    // system clock
  input wire logic phase_on_i,               // line phase reaches the comparator
  input wire logic cont_ok_i,                // solenoid and anode path intact
  input wire logic fire_ok_i,                // controller and scr able to fire
  input wire gfst_pkg::gfst_drive_t drive_i, // test drive from the sequencer
  output gfst_pkg::gfst_sense_t sense_o      // comparator levels
);
  logic [4:0] cyc = 5'h00;
  logic fired = 1'b0;
  // a 20-cycle line period keeps several half-cycles inside the shortened time-out
  always @(negedge clk_i) begin
    cyc <= (cyc == 5'h13) ? 5'h00 : cyc + 5'h01;
  end
  // scr fires on the simulated fault and stays on until the next positive half
  always @(negedge clk_i) begin
    if (drive_i.fault_inject && fire_ok_i) begin
      fired <= 1'b1;
    end else if (cyc == 5'h13) begin
      fired <= 1'b0;
    end
  end
  logic pos;
  logic near;
  logic anode;
  assign pos = phase_on_i && (cyc < 5'h0a);
  assign near = phase_on_i && (cyc >= 5'h07) && (cyc < 5'h0a);
  // the anode holds charge from the line or the bias until the scr discharges it
  assign anode = cont_ok_i && !fired && (pos || drive_i.bias_en);
  // one driver for the whole struct
  assign sense_o = {pos, near, anode};
endmodule : gfst_partner

// ==== gfst_seq_test.sv ====
// self-checking bench of the self-test sequencer
`timescale 1ns/1ps
module gfst_seq_test;
  import gfst_pkg::*;
  localparam int TK = 4;
  localparam int FT = 20;
  localparam int PT = 50;
  localparam int TO = 30;
  localparam int PH = 10;
  localparam int BT = 3;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic phase_on = 1'b1;
  logic cont_ok = 1'b1;
  logic fire_ok = 1'b1;
  gfst_sense_t sense;
  gfst_drive_t drive;
  logic alarm;
  logic active;
  logic pass;
  logic phase_fail;
  int n_fail = 0;
  int num_checks = 0;
  always #4 clk_i = ~clk_i;
  gfst_seq #(.TICK_CYC(TK), .FIRST_T(FT), .PERIOD_T(PT), .TESTOUT_T(TO), .PHASE_T(PH),
    .BLINK_T(BT)) uut (.clk_i(clk_i), .rstn_i(rstn_i), .sense_i(sense), .drive_o(drive),
    .end_of_life_alarm_o(alarm), .test_active_o(active), .pass_o(pass),
    .phase_fail_o(phase_fail));
  gfst_partner far_end (.clk_i(clk_i), .phase_on_i(phase_on), .cont_ok_i(cont_ok),
    .fire_ok_i(fire_ok), .drive_i(drive), .sense_o(sense));

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk

  // 0 active, 1 pass, 2 alarm high, 3 alarm low; n counts cycles waited
  task automatic wait_hi(input int which, input int bound, output int n);
    logic v;
    n = 0;
    do begin
      @(negedge clk_i);
      #1;
      n++;
      v = (which == 0) ? active : (which == 1) ? pass : (which == 2) ? alarm : ~alarm;
      if (n > bound) begin
        n_fail++;
        $display("unexpected wait %0d: expected high seen low", which);
        stop_test();
      end
    end while (v !== 1'b1);
  endtask : wait_hi

  task automatic do_reset(input logic [2:0] lines);
    @(negedge clk_i);
    rstn_i = 1'b0;
    {phase_on, cont_ok, fire_ok} = lines;
    repeat (3) @(negedge clk_i);
    chk("outputs in reset", {drive, alarm, active, pass, phase_fail}, 32'h0);
    rstn_i = 1'b1;
  endtask : do_reset

  task automatic test_pass();
    int n;
    logic seen_inj;
    gfst_sense_t ps;
    gfst_drive_t pd;
    do_reset(3'b111);
    wait_hi(0, 200, n);
    chk("first delay", n >= FT * TK - TK && n <= FT * TK + 2 * TK, 1);
    for (int c = 0; c < 2; c++) begin
      seen_inj = 1'b0;
      n = 0;
      ps = sense;
      pd = drive;
      while (pass !== 1'b1 && n < 200) begin
        @(negedge clk_i);
        #1;
        n++;
        if (pd.fault_inject && !ps.anode_sense) chk("drive after fire", drive, 0);
        if (drive.fault_inject === 1'b1 && !seen_inj) begin
          seen_inj = 1'b1;
          chk("bias before injection", drive.bias_en, 1);
          chk("phase at injection", sense.pos_half, 0);
        end
        ps = sense;
        pd = drive;
      end
      chk("pass pulse", pass, 1);
      if (pass !== 1'b1) stop_test();
      chk("injection seen", seen_inj, 1);
      chk("idle after pass", {drive, active, alarm}, 0);
      if (c == 0) begin
        wait_hi(0, 400, n);
        chk("period delay", n >= PT * TK - TK && n <= PT * TK + 2 * TK, 1);
      end
    end
  endtask : test_pass

  // a dead scr path, or a broken anode path, must end in the alarm after retries
  task automatic test_fault(input logic no_cont);
    int n;
    do_reset({1'b1, ~no_cont, no_cont});
    wait_hi(0, 200, n);
    wait_hi(2, 300, n);
    chk("test time-out", n >= TO * TK - TK && n <= TO * TK + 2 * TK, 1);
    chk("phase flag", phase_fail, 0);
    wait_hi(3, 100, n);
    chk("alarm high time", n >= BT * TK - TK && n <= BT * TK + TK, 1);
    wait_hi(2, 100, n);
    chk("alarm low time", n >= BT * TK - TK && n <= BT * TK + TK, 1);
  endtask : test_fault

  task automatic test_phase();
    int n;
    do_reset(3'b011);
    wait_hi(2, 200, n);
    chk("phase time-out", n >= PH * TK - TK && n <= PH * TK + 2 * TK, 1);
    chk("phase flag", phase_fail, 1);
    chk("no test run", active, 0);
  endtask : test_phase

  initial begin
    test_pass();
    test_fault(1'b0);
    test_fault(1'b1);
    test_phase();
    stop_test();
  end
endmodule : gfst_seq_test
